// [logic/gcs_seq.sv]
// Chopped-conversion sequencer with APB register access.
// Assumes APB inputs and the start pin are synchronous to I_CLK_SYS and
// that the filter word is valid when a conversion period ends.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps

// Contract
// - chop enabled means two internal conversions per output result.
// - first conversion of a pair uses normal input polarity.
// - second conversion of a pair uses swapped input polarity.
// - result is the mean of normal and reversed conversion values.
// - one enable bit in the rate register switches chop mode.
// - no chopped result before two settled conversions are complete.
// - low-latency filter gives first chopped result after about two periods.
// - sinc3 filter gives first chopped result after about six periods.
// - continuous chop results after the first take half the first time.
// - alternate polarities pipelined so each conversion yields a new average.
// - low-latency chop timing follows the tabulated modulator-period counts.
// - each chopped output averages the two latest opposite conversions.
// - settling delay applies to both conversions, 14 periods by default.
// - a sequence starts on start pin rise or a start command.
module gcs_seq #(
  parameter int P_MOD_DIV = gcs_pkg::MOD_DIV
) (
  input  wire logic               I_CLK_SYS,
  input  wire logic               I_RST_B,
  input  wire logic               I_PSEL,
  input  wire logic               I_PENABLE,
  input  wire logic               I_PWRITE,
  input  wire gcs_pkg::gcs_addr_t I_PADDR,
  input  wire gcs_pkg::gcs_word_t I_PWDATA,
  output gcs_pkg::gcs_word_t      O_PRDATA,
  output logic                    O_PREADY,
  output logic                    O_PSLVERR,
  input  wire logic               I_START_PIN,
  input  wire gcs_pkg::gcs_samp_t I_FILT_DATA,
  output logic                    O_SWAP,
  output logic                    O_MOD_RUN,
  output logic                    O_DATA_RDY,
  output gcs_pkg::gcs_samp_t      O_RESULT
);
  import gcs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  gcs_state_e state_ff, nxt_state;
  logic [7:0] ctrl_ff, rate_ff;
  logic       pready_ff, pslverr_ff, pin_q_ff;
  gcs_word_t  prdata_ff, rd_mux;
  logic       chop_ff, cont_ff, filt_ff, swap_ff, have_prev_ff;
  logic       rdy_ff, rdy_flag_ff, run_ff;
  gcs_rate_t  idx_ff;
  gcs_per_t   dly_per_ff;
  logic [16:0] prev_ff;
  gcs_samp_t  result_ff;

  //////////////////////////////////////////////////////////////////////////
  // APB decode; zero-wait answer registered from the setup cycle
  wire setup    = I_PSEL & ~I_PENABLE;
  wire acc      = I_PSEL & I_PENABLE & pready_ff;
  wire wr       = acc & I_PWRITE;
  wire rd       = acc & ~I_PWRITE;
  wire sel_ctrl = (I_PADDR == ADDR_CTRL);
  wire sel_rate = (I_PADDR == ADDR_RATE);
  wire sel_cmd  = (I_PADDR == ADDR_CMD);
  wire sel_stat = (I_PADDR == ADDR_STAT);
  wire sel_res  = (I_PADDR == ADDR_RES);
  wire mapped   = sel_ctrl | sel_rate | sel_cmd | sel_stat | sel_res;
  wire st_idle  = (state_ff == ST_IDLE);
  wire st_dly   = (state_ff == ST_DLY);
  wire st_conv  = (state_ff == ST_CONV);

  // Status word shows live sequencer state
  wire [7:0] stat_w = {4'h0, chop_ff & ~st_idle, rdy_flag_ff, swap_ff,
                       ~st_idle};

  // Read mux; command register reads as zero
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_ctrl) rd_mux = {24'h000000, ctrl_ff};
    if (sel_rate) rd_mux = {24'h000000, rate_ff};
    if (sel_stat) rd_mux = {24'h000000, stat_w};
    if (sel_res)  rd_mux = {16'h0000, result_ff};
  end

  // Answer flops: ready in the first access cycle, error if unmapped
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      prdata_ff  <= (setup & ~I_PWRITE) ? rd_mux : 32'h00000000;
    end
  end

  // Software-written configuration
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_ff <= CTRL_RST;
      rate_ff <= RATE_RST;
    end else begin
      if (wr & sel_ctrl) ctrl_ff <= I_PWDATA[7:0];
      if (wr & sel_rate) rate_ff <= I_PWDATA[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Start and stop events; the pin is already synchronous
  wire cmd_start = wr & sel_cmd & I_PWDATA[CMD_START_BIT];
  wire stop      = wr & sel_cmd & I_PWDATA[CMD_STOP_BIT];
  wire pin_rise  = I_START_PIN & ~pin_q_ff;
  wire start_ev  = st_idle & (cmd_start | pin_rise) & ~stop;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) pin_q_ff <= 1'b0;
    else          pin_q_ff <= I_START_PIN;
  end

  // Period lookup from the settings latched at start
  wire gcs_rate_t idx_w = (rate_ff[3:0] > RATE_LAST) ? RATE_LAST
                                                     : rate_ff[3:0];
  wire gcs_per_t conv_per = filt_ff ? LL_PER[idx_ff]
                                    : SINC_PER[idx_ff];
  wire [2:0] dly_code = ctrl_ff[CTRL_DLY_LSB +: 3];
  wire gcs_per_t dly_w = 20'(DLY_UNIT * ({17'h00000, dly_code} + 20'h1));

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  logic     tmr_done;
  wire      dly_end  = tmr_done & st_dly;
  wire      conv_end = tmr_done & st_conv;
  // Chop: a lone first conversion always needs its partner
  wire      again    = chop_ff ? (cont_ff | ~have_prev_ff) : cont_ff;
  // A stop drops any reload; the timer then runs out unobserved
  wire      tmr_load = start_ev | (dly_end & ~stop)
                     | (conv_end & ~stop & again);
  // Later chop delays reuse the setting latched at start
  wire gcs_per_t tmr_val = (nxt_state != ST_DLY) ? conv_per
                         : st_idle ? dly_w : dly_per_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_ev) nxt_state = ST_DLY;
      end
      ST_DLY: begin
        if (stop)         nxt_state = ST_IDLE;
        else if (dly_end) nxt_state = ST_CONV;
      end
      ST_CONV: begin
        // Chop re-settles after every swap, so the delay repeats
        if (stop)          nxt_state = ST_IDLE;
        else if (conv_end) nxt_state = !again ? ST_IDLE
                                     : chop_ff ? ST_DLY : ST_CONV;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) state_ff <= ST_IDLE;
    else          state_ff <= nxt_state;
  end

  // One shared timer for delay and conversion; ends are gated by state
  gcs_mod_timer #(
    .P_DIV(P_MOD_DIV)
  ) u_timer (
    .i_clk    (I_CLK_SYS),
    .i_rst_b  (I_RST_B),
    .i_load   (tmr_load),
    .i_periods(tmr_val),
    .o_done   (tmr_done),
    .o_busy   ()
  );

  // Settings frozen for the whole sequence
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      chop_ff    <= 1'b0;
      cont_ff    <= 1'b0;
      filt_ff    <= 1'b0;
      idx_ff     <= 4'h0;
      dly_per_ff <= 20'h00000;
    end else if (start_ev) begin
      chop_ff    <= rate_ff[RATE_CHOP_BIT];
      cont_ff    <= ctrl_ff[CTRL_CONT_BIT];
      filt_ff    <= rate_ff[RATE_FILT_BIT];
      idx_ff     <= idx_w;
      dly_per_ff <= dly_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Data path: reversed samples are negated so the mean cancels offset
  wire [16:0] samp_s  = swap_ff ? -{I_FILT_DATA[15], I_FILT_DATA}
                                :  {I_FILT_DATA[15], I_FILT_DATA};
  // prev_ff holds the sign-corrected word of either polarity
  wire [17:0] sum_w   = {prev_ff[16], prev_ff} + {samp_s[16], samp_s};
  // Only +32768 can overflow; clip it rather than wrap
  wire        ovf_w   = ~sum_w[17] & sum_w[16];
  wire gcs_samp_t avg_w = ovf_w ? 16'h7FFF : sum_w[16:1];

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      swap_ff      <= 1'b0;
      have_prev_ff <= 1'b0;
      prev_ff      <= 17'h00000;
      result_ff    <= 16'h0000;
      rdy_ff       <= 1'b0;
    end else begin
      rdy_ff <= 1'b0;
      if (start_ev | stop) begin
        swap_ff      <= 1'b0;
        have_prev_ff <= 1'b0;
      end else if (conv_end) begin
        prev_ff      <= samp_s;
        have_prev_ff <= 1'b1;
        swap_ff      <= chop_ff & ~swap_ff;
        result_ff    <= chop_ff ? avg_w : I_FILT_DATA;
        rdy_ff       <= ~chop_ff | have_prev_ff;
      end
    end
  end

  // Sticky ready flag: a new result wins over a result read
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rdy_flag_ff <= 1'b0;
      run_ff      <= 1'b0;
    end else begin
      rdy_flag_ff <= rdy_ff | (rdy_flag_ff & ~(rd & sel_res));
      run_ff      <= (nxt_state == ST_CONV);
    end
  end

  assign O_PRDATA   = prdata_ff;
  assign O_PREADY   = pready_ff;
  assign O_PSLVERR  = pslverr_ff;
  assign O_SWAP     = swap_ff;
  assign O_MOD_RUN  = run_ff;
  assign O_DATA_RDY = rdy_ff;
  assign O_RESULT   = result_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checking helpers: cycle counts since start and since last result
  // They feed assertions and covers only and drive no output
  logic [31:0] cyc_ff, since_ff;
  logic        first_pend_ff, conv_two_ff, had_ff;
  wire [31:0]  per_sum  = {12'h000, dly_per_ff} + {12'h000, conv_per};
  wire [31:0]  exp_next = 32'(per_sum * 32'(P_MOD_DIV));
  wire [31:0]  exp_first = 32'(2 * exp_next);

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cyc_ff        <= 32'h00000000;
      since_ff      <= 32'h00000000;
      first_pend_ff <= 1'b0;
      conv_two_ff   <= 1'b0;
      had_ff        <= 1'b0;
    end else begin
      cyc_ff   <= start_ev ? 32'h00000000 : cyc_ff + 32'h00000001;
      since_ff <= rdy_ff ? 32'h00000001 : since_ff + 32'h00000001;
      if (start_ev) begin
        first_pend_ff <= 1'b1;
        conv_two_ff   <= 1'b0;
        had_ff        <= 1'b0;
      end else begin
        if (rdy_ff) first_pend_ff <= 1'b0;
        if (rdy_ff) had_ff <= 1'b1;
        if (conv_end & have_prev_ff) conv_two_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Rule checks, all on the system clock and held off in reset
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  start_norm_a: assert property (
    start_ev |=> !swap_ff ##1 !swap_ff)
    else $error("pair did not start at normal polarity");
  swap_flip_a: assert property (
    conv_end && chop_ff && !stop |=> swap_ff != $past(swap_ff))
    else $error("polarity not swapped after conversion");
  mean_val_a: assert property (
    conv_end && chop_ff && have_prev_ff && !stop
      |=> O_DATA_RDY && O_RESULT == $past(avg_w))
    else $error("chopped result is not the pair mean");
  chop_latch_a: assert property (
    start_ev |=> chop_ff == $past(rate_ff[RATE_CHOP_BIT]))
    else $error("chop enable not taken from rate register");
  no_early_a: assert property (
    O_DATA_RDY && chop_ff |-> conv_two_ff)
    else $error("chopped result before two conversions");
  first_time_a: assert property (
    O_DATA_RDY && chop_ff && first_pend_ff |-> cyc_ff == exp_first)
    else $error("first chopped result at wrong time");
  next_time_a: assert property (
    O_DATA_RDY && chop_ff && had_ff |-> since_ff == exp_next)
    else $error("later chopped result at wrong time");
  pair_go_a: assert property (
    conv_end && chop_ff && !have_prev_ff && !stop |=> st_dly)
    else $error("second conversion of pair not started");
  plain_conv_a: assert property (
    st_conv && !chop_ff |-> !swap_ff)
    else $error("inputs swapped with chop disabled");
  start_go_a: assert property (
    st_idle && pin_rise && !stop |=> st_dly ##1 st_dly)
    else $error("start pin edge did not begin a sequence");
  apb_ans_a: assert property (
    setup |=> O_PREADY && O_PSLVERR == !$past(mapped))
    else $error("APB answer missing");
  // Plain results, sequence ends, re-settling, strobe width, stop and bus pacing
  plain_res_a: assert property (
    conv_end && !chop_ff && !stop
      |=> O_DATA_RDY && O_RESULT == $past(I_FILT_DATA))
    else $error("unchopped result is not the filter word");
  single_end_a: assert property (
    conv_end && chop_ff && have_prev_ff && !cont_ff && !stop |=> st_idle)
    else $error("single chopped pair did not end idle");
  chop_redly_a: assert property (
    conv_end && chop_ff && cont_ff && !stop |=> st_dly)
    else $error("settling delay not repeated after swap");
  rdy_pulse_a: assert property (
    O_DATA_RDY |=> !O_DATA_RDY)
    else $error("result strobe longer than one cycle");
  stop_idle_a: assert property (
    stop |=> st_idle && !O_SWAP)
    else $error("stop left sequence running or inputs reversed");
  apb_once_a: assert property (
    O_PREADY |=> !O_PREADY)
    else $error("APB ready held past one cycle");

  // Main scenarios
  chop_cont_c:  cover property (O_DATA_RDY && chop_ff && had_ff);
  clamp_c:      cover property (start_ev && rate_ff[3:0] > RATE_LAST);
  sinc_first_c: cover property (O_DATA_RDY && chop_ff && !filt_ff);
  plain_res_c:  cover property (O_DATA_RDY && !chop_ff);
  stop_run_c:   cover property (stop && st_conv);

endmodule : gcs_seq

// [logic/gcs_pkg.sv]
// Constants, types and register map of the chopped-conversion sequencer.
// Assumes one 10 MHz system clock that also serves as the converter clock.
package gcs_pkg;

  typedef logic [7:0]  gcs_addr_t;
  typedef logic [31:0] gcs_word_t;
  typedef logic [15:0] gcs_samp_t;
  typedef logic [19:0] gcs_per_t;
  typedef logic [3:0]  gcs_rate_t;

  //////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam gcs_addr_t ADDR_CTRL = 8'h00;
  localparam gcs_addr_t ADDR_RATE = 8'h04;
  localparam gcs_addr_t ADDR_CMD  = 8'h08;
  localparam gcs_addr_t ADDR_STAT = 8'h0C;
  localparam gcs_addr_t ADDR_RES  = 8'h10;

  // Field positions
  localparam int CTRL_CONT_BIT  = 0;
  localparam int CTRL_DLY_LSB   = 1;
  localparam int RATE_FILT_BIT  = 4;
  localparam int RATE_CHOP_BIT  = 5;
  localparam int CMD_START_BIT  = 0;
  localparam int CMD_STOP_BIT   = 1;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SWAP_BIT  = 1;
  localparam int STAT_RDY_BIT   = 2;
  localparam int STAT_CHOP_BIT  = 3;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h1D;

  //////////////////////////////////////////////////////////////////////////
  // Timing: modulator period in system clocks, delay step in periods
  localparam int        MOD_DIV   = 16;
  localparam gcs_per_t  DLY_UNIT  = 20'h0000E;
  localparam gcs_rate_t RATE_LAST = 4'hD;

  // Modulator periods per chopped conversion, slowest rate first
  localparam gcs_per_t LL_PER [14] = '{
    20'h19681, 20'h0CE81, 20'h06A81, 20'h03C41, 20'h03881, 20'h01428,
    20'h010E9, 20'h00A28, 20'h00528, 20'h002A8, 20'h00168, 20'h00128,
    20'h000A8, 20'h00068};
  localparam gcs_per_t SINC_PER [14] = '{
    20'h4B041, 20'h25841, 20'h12C41, 20'h0B441, 20'h09641, 20'h03C41,
    20'h03239, 20'h01E41, 20'h00F41, 20'h007C1, 20'h00401, 20'h00328,
    20'h001A8, 20'h000E8};

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DLY  = 3'b010,
    ST_CONV = 3'b100
  } gcs_state_e;

endpackage : gcs_pkg

// [logic/gcs_mod_timer.sv]
// Modulator-period timer: divides the system clock to modulator periods
// and counts a loaded number of them. Assumes i_periods is held while busy.
`timescale 1ns/100ps
module gcs_mod_timer #(
  parameter int P_DIV = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_load,
  input  wire gcs_pkg::gcs_per_t i_periods,
  output logic                  o_done,
  output logic                  o_busy
);
  import gcs_pkg::*;

  logic [7:0] div_ff;
  gcs_per_t   cnt_ff;
  logic       busy_ff;
  logic       tick;

  // One tick per modulator period; done is the last tick itself
  assign tick   = busy_ff & (div_ff == 8'(P_DIV - 1));
  assign o_done = tick & (cnt_ff <= 20'h00001);
  assign o_busy = busy_ff;

  // Load restarts the period count, even while busy
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_ff  <= 8'h00;
      cnt_ff  <= 20'h00000;
      busy_ff <= 1'b0;
    end else if (i_load) begin
      div_ff  <= 8'h00;
      cnt_ff  <= i_periods;
      busy_ff <= 1'b1;
    end else if (tick) begin
      div_ff  <= 8'h00;
      cnt_ff  <= cnt_ff - 20'h00001;
      busy_ff <= ~o_done;
    end else if (busy_ff) begin
      div_ff  <= div_ff + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  done_busy_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_done && !i_load |=> !busy_ff)
    else $error("timer kept running after done");

endmodule : gcs_mod_timer

// [tb/gcs_filt_model.sv]
// Behavioural model of the modulator and filter behind the sequencer.
// Assumes the word is taken at, or one cycle after, a conversion end.
`timescale 1ns/100ps
module gcs_filt_model
  import gcs_pkg::*;
(
  input  wire logic      i_clk,
  input  wire logic      i_rst_b,
  input  wire logic      i_swap,
  input  wire logic      i_mod_run,
  input  wire gcs_samp_t i_signal,
  input  wire gcs_samp_t i_offset,
  output gcs_samp_t      o_filt_data
);
  logic      run_ff;
  logic      pol_ff;
  gcs_samp_t junk_ff;
  // Offset stays put while the input is reversed, so a mean cancels it
  wire logic      pol     = i_mod_run ? i_swap : pol_ff;
  wire gcs_samp_t settled = (pol ? -i_signal : i_signal) + i_offset;

  // Polarity of the running conversion, kept one cycle past its end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_ff  <= 1'b0;
      pol_ff  <= 1'b0;
      junk_ff <= 16'h5A5A;
    end else begin
      run_ff  <= i_mod_run;
      pol_ff  <= i_mod_run ? i_swap : pol_ff;
      junk_ff <= {junk_ff[14:0], ~junk_ff[15]};
    end
  end

  // Outside the sampling window the word moves every cycle, never stale
  assign o_filt_data = (i_mod_run || run_ff) ? settled : junk_ff;
endmodule : gcs_filt_model

// [tb/tb_gcs_seq.sv]
// Self-checking bench for the chopped-conversion sequencer.
// Assumes P_MOD_DIV = 1, so one modulator period is one clock.
`timescale 1ns/100ps
module tb_gcs_seq;
  import gcs_pkg::*;
  localparam int         LL_C [4] = '{360, 296, 168, 104};
  localparam int         SN_C [4] = '{1025, 808, 424, 232};
  localparam gcs_addr_t  RA [5]   = '{ADDR_CTRL, ADDR_RATE, ADDR_CMD,
                                      ADDR_STAT, ADDR_RES};
  localparam logic [7:0] RV [5]   = '{CTRL_RST, RATE_RST, 8'h00, 8'h00,
                                      8'h00};
  logic      I_CLK_SYS   = 1'b0;
  logic      I_RST_B     = 1'b0;
  logic      I_PSEL      = 1'b0;
  logic      I_PENABLE   = 1'b0;
  logic      I_PWRITE    = 1'b0;
  gcs_addr_t I_PADDR     = 8'h00;
  gcs_word_t I_PWDATA    = 32'h0000_0000;
  logic      I_START_PIN = 1'b0;
  gcs_samp_t I_FILT_DATA;
  gcs_word_t O_PRDATA;
  logic      O_PREADY, O_PSLVERR, O_SWAP, O_MOD_RUN, O_DATA_RDY;
  gcs_samp_t O_RESULT;
  gcs_samp_t sig = 16'h0000;
  gcs_samp_t ofs = 16'h0000;
  gcs_word_t rd_v, wr_v;
  logic      err_v, run_q = 1'b0, exp_chop = 1'b0;
  int        cyc = 0, t_wr, n_runs = 0, seed = 64832;
  int        fail_count = 0, n_tests = 0, i;

  gcs_seq #(.P_MOD_DIV(1)) u_gcs_seq (.I_CLK_SYS, .I_RST_B, .I_PSEL,
    .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY,
    .O_PSLVERR, .I_START_PIN, .I_FILT_DATA, .O_SWAP, .O_MOD_RUN,
    .O_DATA_RDY, .O_RESULT);
  gcs_filt_model u_gcs_filt_model (.i_clk(I_CLK_SYS), .i_rst_b(I_RST_B),
    .i_swap(O_SWAP), .i_mod_run(O_MOD_RUN), .i_signal(sig),
    .i_offset(ofs), .o_filt_data(I_FILT_DATA));

  always #50 I_CLK_SYS = ~I_CLK_SYS;
  always @(posedge I_CLK_SYS) cyc <= cyc + 1;

  // Polarity at each rise of O_MOD_RUN: alternates only when chopped
  always @(posedge I_CLK_SYS) begin
    if (I_RST_B && O_MOD_RUN === 1'b1 && run_q !== 1'b1) begin
      chk_val(32'(O_SWAP), 32'(exp_chop & n_runs[0]));
      n_runs = n_runs + 1;
    end
    run_q <= O_MOD_RUN;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input gcs_word_t got, input gcs_word_t exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_cyc(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cyc

  // One APB transfer; entered and left right after a rising edge
  task automatic apb(input logic wr, input gcs_addr_t a, input gcs_word_t wd);
    I_PSEL   <= 1'b1;
    I_PWRITE <= wr;
    I_PADDR  <= a;
    I_PWDATA <= wd;
    @(posedge I_CLK_SYS);
    I_PENABLE <= 1'b1;
    @(posedge I_CLK_SYS);
    // Only the watchdog bounds this wait
    while (O_PREADY !== 1'b1) @(posedge I_CLK_SYS);
    rd_v  = O_PRDATA;
    err_v = O_PSLVERR;
    t_wr  = cyc;
    I_PSEL    <= 1'b0;
    I_PENABLE <= 1'b0;
    @(posedge I_CLK_SYS);
  endtask : apb

  // Bounded wait for the result pulse; returns the cycle it was seen
  task automatic wait_rdy(output int t);
    int n;
    n = 0;
    do begin
      @(posedge I_CLK_SYS);
      n++;
    end while (O_DATA_RDY !== 1'b1 && n < 6000);
    if (n == 6000) begin
      fail_count++;
      summarize();
    end
    t = cyc;
  endtask : wait_rdy

  // Configure, start, time every result and check its value and status
  task automatic run_conv(input int rate, ll, chop, dly, cont, pin, nres,
                          dup);
    int        t0, t, c, d, s, o, k;
    gcs_samp_t r;
    // Codes above the table clamp to the fastest rate
    k = (rate > 13) ? 3 : rate - 10;
    c = ll ? LL_C[k] : SN_C[k];
    d = 14 * (dly + 1);
    s = $random(seed) % 16000;
    o = $random(seed) % 1000;
    sig <= 16'(s);
    ofs <= 16'(o);
    r = chop ? 16'(s) : 16'(s + o);
    exp_chop = chop[0];
    n_runs = 0;
    apb(1'b1, ADDR_CTRL, 32'(dly * 2 + cont));
    apb(1'b1, ADDR_RATE, 32'(chop * 32 + ll * 16 + rate));
    if (pin) begin
      I_START_PIN <= 1'b1;
      @(posedge I_CLK_SYS);
      t0 = cyc;
      I_START_PIN <= 1'b0;
    end else begin
      apb(1'b1, ADDR_CMD, 32'h1);
      t0 = t_wr;
    end
    // A second start while busy must not disturb the timing
    if (dup) apb(1'b1, ADDR_CMD, 32'h1);
    for (k = 0; k < nres; k++) begin
      wait_rdy(t);
      if (k == 0)
        chk_cyc(t - t0, chop ? 2*(d+c)+1 : d+c+1);
      else
        chk_cyc(t - t0, chop ? d + c : c);
      chk_val(32'(O_RESULT), 32'(r));
      t0 = t;
    end
    if (cont) apb(1'b1, ADDR_CMD, 32'h2);
    else repeat (2) @(posedge I_CLK_SYS);
    chk_val(32'(O_SWAP), 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_val(rd_v & 32'h7, 32'h4);
    apb(1'b0, ADDR_RES, 32'h0);
    chk_val(rd_v, 32'(r));
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_val(rd_v & 32'h7, 32'h0);
  endtask : run_conv

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole run needs well under 60k cycles
  initial begin
    #(64'd60000 * 64'd100);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge I_CLK_SYS);
    I_RST_B <= 1'b1;
    @(posedge I_CLK_SYS);
    // Reset values, unmapped and read-only places
    for (i = 0; i < 5; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk_val(rd_v, {24'h0, RV[i]});
    end
    apb(1'b0, 8'h14, 32'h0);
    chk_val({rd_v[30:0], err_v}, 32'h1);
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk_val(32'(err_v), 32'h1);
    apb(1'b1, ADDR_STAT, 32'h0000_00FF);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk_val(rd_v, 32'h0);
    wr_v = ({$random(seed)} & 32'hFFFF_FFF0) | 32'h9;
    apb(1'b1, ADDR_RATE, wr_v);
    chk_val(rd_v, 32'h0);
    apb(1'b0, ADDR_RATE, 32'h0);
    chk_val(rd_v, {24'h000000, wr_v[7:0]});
    // Corner cases: clamped short chop, slow settling, continuous, no chop
    run_conv(15, 1, 1, 0, 0, 0, 1, 1);
    run_conv(13, 0, 1, 7, 0, 0, 1, 0);
    run_conv(12, 1, 1, 2, 1, 1, 4, 0);
    run_conv(11, 0, 0, 3, 1, 0, 3, 0);
    run_conv(10, 1, 0, 0, 0, 1, 1, 0);
    // Random settings over the fast rates
    for (i = 0; i < 6; i++) begin
      run_conv(10 + {$random(seed)} % 4, {$random(seed)} % 2,
               {$random(seed)} % 2, {$random(seed)} % 8, i % 2,
               {$random(seed)} % 2, 1 + (i % 2) * 2, 0);
    end
    summarize();
  end
endmodule : tb_gcs_seq
